// file: dv/test_tscr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "tscr_defs.svh"

module test_tscr_regs;
   import tscr_pkg::*;

   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic            clk        = 1'b0;
   logic            sys_rst    = 1'b1;
   logic            por_rst    = 1'b1;
   logic            otp_load   = 1'b0;
   logic            all_paused = 1'b0;
   logic [31:0]     otp_word   = 32'h0000_0000;
   logic [14:0]     boot_in    = 15'h52D6;
   logic [3:0]      rosc_pin   = 4'h0;
   tscr_ps_req_t    ps_req     = '0;
   tscr_ps_rsp_t    ps_rsp;
   tscr_tile_ctrl_t tile_ctrl;
   tscr_sec_cfg_t   sec_cfg;
   logic            div_act;
   logic            tx_clk;
   logic            tx_launch;
   logic            core_en;
   logic            peri_en;
   int              n_errors   = 0;
   int              n_compared = 0;

   // Half period of the 50 MHz clock
   always #10 clk = ~clk;

   tscr_regs u_dut (
      .clk             (clk),
      .sys_rst         (sys_rst),
      .por_rst         (por_rst),
      .ps_req          (ps_req),
      .ps_rsp          (ps_rsp),
      .proc_num        (boot_in[14:7]),
      .boot_override   (boot_in[6]),
      .core1_off       (boot_in[5]),
      .skip_otp_poll   (boot_in[4]),
      .boot_ram        (boot_in[3]),
      .boot_jtag       (boot_in[2]),
      .pll_mode_pin    (boot_in[1:0]),
      .otp_load        (otp_load),
      .otp_word        (otp_word),
      .all_paused      (all_paused),
      .rosc_pin        (rosc_pin),
      .tile_ctrl       (tile_ctrl),
      .sec_cfg         (sec_cfg),
      .clk_div_active  (div_act),
      .rgmii_tx_clk    (tx_clk),
      .rgmii_tx_launch (tx_launch),
      .rosc_core_en    (core_en),
      .rosc_peri_en    (peri_en)
   );

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One access; ack is looked at in the single cycle it stands
   task automatic acc(input logic wr, input logic [7:0] num,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      logic [15:0] rid;
      // the bus carries the number part of the resource id
      rid    = {num, 8'h0B};
      ps_req = {wr, ~wr, rid[15:8], wd};
      @(negedge clk);
      ps_req = '0;
      chk("ack", {31'h0, ps_rsp.ack}, 32'h1);
      rd = ps_rsp.rdata;
      er = ps_rsp.err;
      // Let an edge pass so the next request is a fresh pulse
      @(negedge clk);
   endtask

   task automatic wr(input logic [7:0] num, input logic [31:0] wd,
                     input logic exp_err);
      logic [31:0] d;
      logic        e;
      acc(1'b1, num, wd, d, e);
      chk("write err", {31'h0, e}, {31'h0, exp_err});
   endtask

   task automatic rd(input string nm, input logic [7:0] num,
                     input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      acc(1'b0, num, 32'h0, d, e);
      chk(nm, d, exp);
   endtask

   // Mid-run reset; boot pins must be steady past the sync depth
   task automatic do_reset(input logic [14:0] boot);
      boot_in = boot;
      sys_rst = 1'b1;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
   endtask

   function automatic logic [31:0] boot_word(input logic [14:0] b);
      return {8'h00, b[14:7], 7'h00, b[6], 2'h0, b[5:0]};
   endfunction

   task automatic pulse_pins(input int n);
      repeat (n) begin
         rosc_pin = 4'hF;
         repeat (2) @(negedge clk);
         rosc_pin = 4'h0;
         repeat (2) @(negedge clk);
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset_and_map();
      rd("tile ctrl rst", `TSCR_REG_TILE_CTRL, 32'h0);
      rd("sec rst", `TSCR_REG_SEC_CFG, 32'h0);
      rd("rosc ctrl rst", `TSCR_REG_ROSC_CTRL, 32'h0);
      rd("boot", `TSCR_REG_BOOT_STAT, boot_word(boot_in));
      wr(`TSCR_REG_BOOT_STAT, 32'hFFFF_FFFF, 1'b1);
      rd("boot ro", `TSCR_REG_BOOT_STAT, boot_word(boot_in));
      wr(8'h07, 32'h0000_1234, 1'b1);
      rd("unmapped", 8'h04, 32'h0);
      wr(`TSCR_REG_TILE_CTRL, 32'hFFFF_FFFF, 1'b0);
      chk("tile port", tile_ctrl, 32'h03FF_FF36);
      rd("tile all", `TSCR_REG_TILE_CTRL, 32'h03FF_FF36);
   endtask

   task automatic t_low_power();
      wr(`TSCR_REG_TILE_CTRL, 32'h0000_0030, 1'b0);
      all_paused = 1'b0;
      repeat (2) @(negedge clk);
      chk("dyn busy", {31'h0, div_act}, 32'h0);
      all_paused = 1'b1;
      repeat (2) @(negedge clk);
      chk("dyn paused", {31'h0, div_act}, 32'h1);
      wr(`TSCR_REG_TILE_CTRL, 32'h0000_0010, 1'b0);
      all_paused = 1'b0;
      repeat (2) @(negedge clk);
      chk("static", {31'h0, div_act}, 32'h1);
   endtask

   // Divider 3 gives a period of 4 cycles; launch 2 cycles after rise
   task automatic t_tx_clock();
      int   k;
      int   l;
      int   r;
      logic prev;
      wr(`TSCR_REG_TILE_CTRL, 32'h0008_0700, 1'b0);
      k = 0;
      while (!(tx_clk === 1'b0) && k < 20) begin
         @(negedge clk);
         k++;
      end
      while (!(tx_clk === 1'b1) && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk("tx rise", {31'h0, tx_clk}, 32'h1);
      l = 0;
      r = 0;
      prev = 1'b1;
      for (int i = 1; i <= 8; i++) begin
         @(negedge clk);
         if (tx_launch === 1'b1 && l == 0) l = i;
         if (tx_clk === 1'b1 && prev === 1'b0 && r == 0) r = i;
         prev = tx_clk;
      end
      chk("tx period", r, 32'd4);
      chk("tx launch", l, 32'd2);
   endtask

   task automatic t_ring_osc();
      wr(`TSCR_REG_ROSC_CTRL, 32'hFFFF_FFFE, 1'b0);
      chk("core en", {30'h0, core_en, peri_en}, 32'h2);
      pulse_pins(5);
      wr(`TSCR_REG_ROSC_CTRL, 32'h0000_0001, 1'b0);
      chk("peri en", {30'h0, core_en, peri_en}, 32'h1);
      pulse_pins(3);
      wr(`TSCR_REG_ROSC_CTRL, 32'h0, 1'b0);
      pulse_pins(2);
      repeat (`TSCR_ROSC_SETTLE_CLK) @(negedge clk);
      rd("osc0", 8'h07, 32'd5);
      rd("osc1", 8'h08, 32'd5);
      rd("osc2", 8'h09, 32'd3);
      rd("osc3", 8'h0A, 32'd3);
   endtask

   task automatic t_security();
      otp_word = 32'hFFFF_FFFF;
      otp_load = 1'b1;
      @(negedge clk);
      otp_load = 1'b0;
      chk("otp copy", sec_cfg, 32'h8000_5FB1);
      wr(`TSCR_REG_SEC_CFG, 32'h0, 1'b0);
      rd("locked", `TSCR_REG_SEC_CFG, 32'h8000_5FB1);
      do_reset(15'h2B29);
      rd("sec cleared", `TSCR_REG_SEC_CFG, 32'h0);
      rd("boot again", `TSCR_REG_BOOT_STAT, boot_word(15'h2B29));
      rd("osc kept", 8'h07, 32'd5);
      wr(`TSCR_REG_SEC_CFG, 32'h7FFF_FFFF, 1'b0);
      rd("sec bits", `TSCR_REG_SEC_CFG, 32'h0000_5FB1);
      wr(`TSCR_REG_SEC_CFG, 32'h8000_0010, 1'b0);
      wr(`TSCR_REG_SEC_CFG, 32'h0000_0001, 1'b0);
      chk("lock wr", sec_cfg, 32'h8000_0010);
   endtask

   // ****************************************************************
   // Verdict and run control
   // ****************************************************************
   task automatic wrap_up();
      $display("errors %0d of %0d compared", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // The whole sequence needs well under 1000 cycles
   initial begin
      #(`TSCR_CLK_PERIOD_NS * 5000);
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      por_rst = 1'b0;
      t_reset_and_map();
      t_low_power();
      t_tx_clock();
      t_ring_osc();
      t_security();
      wrap_up();
   end

endmodule

`default_nettype wire

// file: logic/tscr_regs.sv
// Function
// - Tile control holds eight-bit TX data delay in PLL cycles; resets zero.
// - TX clock rises when counter equals divider, falls at divider halved.
// - Tile control enable bit connects the RGMII ports; resets to disabled.
// - Dynamic mode divides only while all active threads pause; else always.
// - Divider enable bit divides the tile clock for low power; resets zero.
// - A tile control bit selects UTMI when one, ULPI when zero.
// - A tile control bit enables the hardware ULPI support module.
// - Boot status is read-only and reports the eight-bit processor number.
// - Boot status shows override, core1 off, RAM, JTAG flags, PLL pins.
// - A boot status flag makes boot ROM skip OTP read-level polling.
// - Security top bit, when set, removes write permission on that register.
// - Security bits disable global debug (bit 14) and JTAG TAP (bit 0).
// - Security holds a lock-all OTP bit plus four per-sector lock bits.
// - Security bits enable OTP redundancy and force booting from OTP.
// - A security bit blocks JTAG access to PLL and boot registers.
// - Security register is loaded as a copy of the OTP security word.
// - Four ring oscillator counters sit at the four numbers after control.
// - Core and peripheral oscillator enable bits; both reset to stopped.
// - Ring oscillators run asynchronously to the tile clock as random source.
// - Each counter is sixteen bits and survives a system reset.
`timescale 1ns/1ps
`default_nettype none
`include "tscr_defs.svh"

module tscr_regs #(
   parameter int ROSC_N = `TSCR_ROSC_COUNT,
   parameter int ROSC_W = 16
) (
   // Clock and resets
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       por_rst,
   // Processor status access
   input  wire tscr_pkg::tscr_ps_req_t     ps_req,
   output tscr_pkg::tscr_ps_rsp_t          ps_rsp,
   // Boot sources, caught while reset is held
   input  wire logic [7:0]                 proc_num,
   input  wire logic                       boot_override,
   input  wire logic                       core1_off,
   input  wire logic                       skip_otp_poll,
   input  wire logic                       boot_ram,
   input  wire logic                       boot_jtag,
   input  wire logic [1:0]                 pll_mode_pin,
   // OTP security word
   input  wire logic                       otp_load,
   input  wire logic [31:0]                otp_word,
   // Thread state
   input  wire logic                       all_paused,
   // Ring oscillator pins
   input  wire logic [ROSC_N-1:0]          rosc_pin,
   // Control outputs
   output tscr_pkg::tscr_tile_ctrl_t       tile_ctrl,
   output tscr_pkg::tscr_sec_cfg_t         sec_cfg,
   output logic                            clk_div_active,
   output logic                            rgmii_tx_clk,
   output logic                            rgmii_tx_launch,
   output logic                            rosc_core_en,
   output logic                            rosc_peri_en
);
   import tscr_pkg::*;

   // Elaboration check: the read path decodes exactly four counters
   // and packs each one into a single 32-bit word
   if (ROSC_N != `TSCR_ROSC_COUNT || ROSC_W < 1 || ROSC_W > 32) begin : g_bad
      $error("tscr_regs: unsupported ring oscillator shape");
   end

   // ****************************************************************
   // Access decode
   // ****************************************************************

   // Register selects by number
   wire sel_tile = (ps_req.num == `TSCR_REG_TILE_CTRL);
   wire sel_boot = (ps_req.num == `TSCR_REG_BOOT_STAT);
   wire sel_sec  = (ps_req.num == `TSCR_REG_SEC_CFG);
   wire sel_rctl = (ps_req.num == `TSCR_REG_ROSC_CTRL);
   // counters sit in the four numbers after the control register
   wire sel_rval = (ps_req.num >= `TSCR_REG_ROSC_VAL0) &&
                   (ps_req.num <= `TSCR_REG_ROSC_VAL3);
   wire [1:0] rval_idx = 2'(ps_req.num - `TSCR_REG_ROSC_VAL0);
   wire       sel_any  = sel_tile | sel_boot | sel_sec | sel_rctl | sel_rval;

   // Write strobes per register
   wire wr_tile = ps_req.wr && sel_tile;
   wire wr_sec  = ps_req.wr && sel_sec;
   wire wr_rctl = ps_req.wr && sel_rctl;

   // Writes to read-only or unknown numbers are answered with an error
   wire wr_bad  = ps_req.wr && !(sel_tile | sel_sec | sel_rctl);
   wire rd_bad  = ps_req.rd && !sel_any;

   // ****************************************************************
   // Tile control
   // ****************************************************************

   wire [31:0] tile_wval = ps_req.wdata & `TSCR_TILE_CTRL_MASK;

   // delay, divider, port enable, divider mode
   // transceiver style, ULPI support; all reset to zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tile_ctrl <= tscr_tile_ctrl_t'(`TSCR_TILE_CTRL_RST);
      end else if (wr_tile) begin
         tile_ctrl <= tscr_tile_ctrl_t'(tile_wval);
      end
   end

   // dynamic mode waits for every active thread to pause
   wire next_div_active = tile_ctrl.div_en &&
                          (!tile_ctrl.div_dyn || all_paused);

   // low power divider request to the clock generator
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_div_active <= 1'b0;
      end else begin
         clk_div_active <= next_div_active;
      end
   end

   // transmit clock runs only while the ports are connected
   // the divider field already holds ratio minus one
   tscr_txclk #(
      .DIV_W (9),
      .DLY_W (8)
   ) u_txclk (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .enable    (tile_ctrl.rgmii_en),
      .div       (tile_ctrl.tx_div),
      .delay     (tile_ctrl.tx_delay),
      .tx_clk    (rgmii_tx_clk),
      .tx_launch (rgmii_tx_launch)
   );

   // ****************************************************************
   // Boot status
   // ****************************************************************

   // PLL mode pins come from outside and pass two stages first
   logic [1:0] pll_sync1;
   logic [1:0] pll_sync2;
   always_ff @(posedge clk) begin
      pll_sync1 <= pll_mode_pin;
      pll_sync2 <= pll_sync1;
   end

   // read-only, caught while reset is held, stable afterwards
   tscr_boot_stat_t boot_stat;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         boot_stat               <= '0;
         boot_stat.proc_num      <= proc_num;
         // boot flags and sampled PLL pins
         boot_stat.boot_override <= boot_override;
         boot_stat.core1_off     <= core1_off;
         boot_stat.boot_ram      <= boot_ram;
         boot_stat.boot_jtag     <= boot_jtag;
         boot_stat.pll_mode      <= pll_sync2;
         boot_stat.skip_otp_poll <= skip_otp_poll;
      end
   end

   // ****************************************************************
   // Security configuration
   // ****************************************************************

   // only documented control bits are kept
   wire [31:0] sec_oval = otp_word & `TSCR_SEC_CFG_MASK;
   wire [31:0] sec_wval = ps_req.wdata & `TSCR_SEC_CFG_MASK;
   // the lock bit removes write permission
   wire        sec_wr_ok = wr_sec && !sec_cfg[`TSCR_SEC_WR_LOCK_BIT];

   // OTP copy wins over a software write in the same cycle
   // once locked, only a reset or an OTP reload can change it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sec_cfg <= tscr_sec_cfg_t'(`TSCR_SEC_CFG_RST);
      end else if (otp_load) begin
         sec_cfg <= tscr_sec_cfg_t'(sec_oval);
      end else if (sec_wr_ok) begin
         sec_cfg <= tscr_sec_cfg_t'(sec_wval);
      end
   end

   // ****************************************************************
   // Ring oscillators
   // ****************************************************************

   // both oscillator groups stopped after reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rosc_core_en <= 1'b0;
         rosc_peri_en <= 1'b0;
      end else if (wr_rctl) begin
         rosc_core_en <= ps_req.wdata[`TSCR_ROSC_CORE_BIT];
         rosc_peri_en <= ps_req.wdata[`TSCR_ROSC_PERI_BIT];
      end
   end

   // counters follow free-running pins, not the tile clock
   // the first two belong to the core group, the last two to peripherals
   logic [ROSC_W-1:0] rosc_cnt [ROSC_N];
   for (genvar g = 0; g < ROSC_N; g++) begin : g_rosc
      tscr_rosc #(
         .CNT_W (ROSC_W)
      ) u_rosc (
         .clk     (clk),
         .por_rst (por_rst),
         .run     ((g < 2) ? rosc_core_en : rosc_peri_en),
         .osc_in  (rosc_pin[g]),
         .count   (rosc_cnt[g])
      );
   end

   // ****************************************************************
   // Read path
   // ****************************************************************

   wire [31:0] rctl_word = {30'h0, rosc_core_en, rosc_peri_en};
   wire [31:0] rval_word = 32'(rosc_cnt[rval_idx]) & `TSCR_ROSC_VAL_MASK;
   wire [31:0] rd_word   =
      sel_tile ? 32'(tile_ctrl) :
      sel_boot ? (32'(boot_stat) & `TSCR_BOOT_STAT_MASK) :
      sel_sec  ? 32'(sec_cfg) :
      sel_rctl ? rctl_word :
      sel_rval ? rval_word : 32'h0000_0000;

   // One answer per request, one cycle later; a locked security
   // write is taken silently, so software sees no error for it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ps_rsp <= '0;
      end else begin
         ps_rsp.ack   <= ps_req.wr | ps_req.rd;
         ps_rsp.err   <= wr_bad | rd_bad;
         ps_rsp.rdata <= ps_req.rd ? rd_word : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Stop counter for the settle check
   logic [3:0] stop_cnt;
   always_ff @(posedge clk) begin
      if (sys_rst || rosc_core_en) begin
         stop_cnt <= 4'h0;
      end else if (stop_cnt != 4'hF) begin
         stop_cnt <= stop_cnt + 4'h1;
      end
   end

   a_tile_write: assert property (
      wr_tile |=> 32'(tile_ctrl) == ($past(ps_req.wdata) &
                                      `TSCR_TILE_CTRL_MASK))
      else $error("tile control write not stored");

   a_tile_rsvd: assert property (
      (32'(tile_ctrl) & ~`TSCR_TILE_CTRL_MASK) == 32'h0)
      else $error("tile control reserved bit set");

   a_div_mode: assert property (
      tile_ctrl.div_en && tile_ctrl.div_dyn && !all_paused
      |=> !clk_div_active)
      else $error("dynamic divider active while a thread runs");

   a_div_static: assert property (
      (tile_ctrl.div_en && !tile_ctrl.div_dyn) [*2] |-> clk_div_active)
      else $error("static divider not active");

   a_sec_locked: assert property (
      sec_cfg.wr_lock && !otp_load |=> $stable(sec_cfg))
      else $error("locked security register changed");

   a_sec_load: assert property (
      otp_load |=> 32'(sec_cfg) == ($past(otp_word) &
                                     `TSCR_SEC_CFG_MASK))
      else $error("security register not copied from OTP");

   a_boot_ro: assert property (
      ps_req.wr && sel_boot |=> ps_rsp.ack && ps_rsp.err)
      else $error("boot status write not refused");

   a_rosc_settle: assert property (
      stop_cnt >= 4'd4 |-> $stable(rosc_cnt[0]) && $stable(rosc_cnt[1]))
      else $error("stopped core oscillator still counting");

   a_rosc_read: assert property (
      ps_req.rd && sel_rval |=>
      ps_rsp.rdata[31:16] == 16'h0000 && ps_rsp.ack && !ps_rsp.err)
      else $error("oscillator counter read malformed");

   a_txclk_off: assert property (
      !tile_ctrl.rgmii_en [*2] |-> !rgmii_tx_clk)
      else $error("transmit clock toggles while ports disabled");

   a_ack_once: assert property (
      !(ps_req.wr | ps_req.rd) |=> !ps_rsp.ack)
      else $error("answer without request");

   c_sec_lock: cover property (sec_cfg.wr_lock && wr_sec);
   c_dyn_div: cover property (tile_ctrl.div_dyn && clk_div_active);
   c_tx_clk: cover property ($rose(rgmii_tx_clk) ##[1:20] rgmii_tx_launch);
   c_rosc_rd: cover property (stop_cnt >= 4'd10 && ps_req.rd && sel_rval);

endmodule

`default_nettype wire

// file: logic/tscr_rosc.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Ring oscillator edge counter
// ****************************************************************
module tscr_rosc #(
   parameter int CNT_W = 16
) (
   // Clock and power-on reset
   input  wire logic             clk,
   input  wire logic             por_rst,
   // Control and oscillator pin
   input  wire logic             run,
   input  wire logic             osc_in,
   // Count
   output logic [CNT_W-1:0]      count
);

   // Elaboration check on the counter width
   if (CNT_W < 1) begin : g_bad
      $error("tscr_rosc: CNT_W must be positive");
   end

   logic sync1;
   logic sync2;
   logic last;

   // Two-stage capture of the free-running oscillator
   always_ff @(posedge clk) begin
      sync1 <= osc_in;
      sync2 <= sync1;
      last  <= sync2;
   end

   // only power-on clears the count, system reset does not
   always_ff @(posedge clk) begin
      if (por_rst) begin
         count <= '0;
      end else if (run && sync2 && !last) begin
         count <= count + 1'b1;
      end
   end

endmodule

`default_nettype wire

// file: logic/tscr_txclk.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Transmit clock divider and data launch delay
// ****************************************************************
module tscr_txclk #(
   parameter int DIV_W = 9,
   parameter int DLY_W = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Settings
   input  wire logic             enable,
   input  wire logic [DIV_W-1:0] div,
   input  wire logic [DLY_W-1:0] delay,
   // Outputs
   output logic                  tx_clk,
   output logic                  tx_launch
);

   // Elaboration check: the halving needs at least two divider bits
   if (DIV_W < 2 || DLY_W < 1) begin : g_bad
      $error("tscr_txclk: widths too small");
   end

   logic [DIV_W-1:0] cnt;
   logic [DLY_W-1:0] dly_cnt;
   logic             armed;

   wire at_top  = (cnt == div);
   wire at_half = (cnt == (div >> 1));

   always_ff @(posedge clk) begin
      if (sys_rst || !enable) begin
         cnt    <= '0;
         tx_clk <= 1'b0;
      end else begin
         cnt <= at_top ? '0 : cnt + 1'b1;
         if (at_top) begin
            tx_clk <= 1'b1;
         end else if (at_half) begin
            tx_clk <= 1'b0;
         end
      end
   end

   // launch data delay cycles after the rise
   always_ff @(posedge clk) begin
      if (sys_rst || !enable) begin
         armed     <= 1'b0;
         dly_cnt   <= '0;
         tx_launch <= 1'b0;
      end else begin
         tx_launch <= (at_top && delay == '0) || (armed && dly_cnt == 1);
         if (at_top) begin
            armed   <= (delay != '0);
            dly_cnt <= delay;
         end else if (armed) begin
            armed   <= (dly_cnt != 1);
            dly_cnt <= dly_cnt - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// file: pkg/tscr_defs.svh
`ifndef TSCR_DEFS_SVH
`define TSCR_DEFS_SVH

// ****************************************************************
// Register numbers
// ****************************************************************
`define TSCR_REG_TILE_CTRL   8'h02
`define TSCR_REG_BOOT_STAT   8'h03
`define TSCR_REG_SEC_CFG     8'h05
`define TSCR_REG_ROSC_CTRL   8'h06
`define TSCR_REG_ROSC_VAL0   8'h07
`define TSCR_REG_ROSC_VAL3   8'h0A

// ****************************************************************
// Implemented-bit masks and reset values
// ****************************************************************
`define TSCR_TILE_CTRL_MASK  32'h03FF_FF36
`define TSCR_TILE_CTRL_RST   32'h0000_0000
`define TSCR_BOOT_STAT_MASK  32'h00FF_013F
`define TSCR_SEC_CFG_MASK    32'h8000_5FB1
`define TSCR_SEC_CFG_RST     32'h0000_0000
`define TSCR_ROSC_CTRL_MASK  32'h0000_0003
`define TSCR_ROSC_CTRL_RST   32'h0000_0000
`define TSCR_ROSC_VAL_MASK   32'h0000_FFFF

// ****************************************************************
// Field positions
// ****************************************************************
`define TSCR_TX_DELAY_LSB    18
`define TSCR_TX_DIV_LSB      9
`define TSCR_SEC_WR_LOCK_BIT 31
`define TSCR_ROSC_CORE_BIT   1
`define TSCR_ROSC_PERI_BIT   0

// ****************************************************************
// Timing
// ****************************************************************
`define TSCR_CLK_PERIOD_NS   20
`define TSCR_ROSC_SETTLE_CLK 10
`define TSCR_ROSC_COUNT      4

`endif

// file: pkg/tscr_pkg.sv
`default_nettype none

// ****************************************************************
// Types of the tile status and control bank
// ****************************************************************
package tscr_pkg;

   // Tile control, laid out as the register word
   typedef struct packed {
      logic [5:0] rsv_hi;
      logic [7:0] tx_delay;
      logic [8:0] tx_div;
      logic       rgmii_en;
      logic [1:0] rsv_mid;
      logic       div_dyn;
      logic       div_en;
      logic       rsv_3;
      logic       utmi_sel;
      logic       ulpi_hw_en;
      logic       rsv_0;
   } tscr_tile_ctrl_t;

   // Boot status, laid out as the register word
   typedef struct packed {
      logic [7:0] rsv_hi;
      logic [7:0] proc_num;
      logic [6:0] rsv_mid;
      logic       boot_override;
      logic [1:0] rsv_lo;
      logic       core1_off;
      logic       skip_otp_poll;
      logic       boot_ram;
      logic       boot_jtag;
      logic [1:0] pll_mode;
   } tscr_boot_stat_t;

   // Security configuration, laid out as the register word
   typedef struct packed {
      logic        wr_lock;
      logic [15:0] rsv_hi;
      logic        dbg_dis;
      logic        rsv_13;
      logic        otp_lock_all;
      logic [3:0]  otp_lock;
      logic        otp_redund;
      logic        rsv_6;
      logic        boot_otp;
      logic        jtag_cfg_dis;
      logic [2:0]  rsv_lo;
      logic        jtag_tap_dis;
   } tscr_sec_cfg_t;

   // Processor status request and answer
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  num;
      logic [31:0] wdata;
   } tscr_ps_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } tscr_ps_rsp_t;

endpackage

`default_nettype wire
